// *** rtl/frame_chip_offset_mapper.sv ***
// Frame number mapper and chip shift rounder behind an AXI4-Lite slave
`timescale 1ns/1ps

// How it works
// - Cell frame low byte is connection frame plus frame shift, modulo 256.
// - Connection frame is cell frame minus frame shift, wrapped modulo 256.
// - Only eight low cell frame bits map; shift and connection frame 8-bit.
// - Frame numbers and frame shift all count whole radio frames.
// - Chip shift has one-chip steps, accepted from 0 through 38399 only.
// - Combined count is frame shift times 38400 plus chip shift.
// - The combined count is rounded to the nearest 256-chip boundary.
// - The 256-chip grid is used whatever the spreading factor, even 512.
// - Remainder 1 to 127 rounds down to the boundary below, with no wrap.
// - Remainder 128 to 255 rounds up, wrapped modulo 256 frames.
// - Remainder zero keeps the combined count unchanged.
// - The rounded value drives the downlink dedicated channel timing.
module frame_chip_offset_mapper
  import frame_chip_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [7:0]       cellFrameOut,
  output logic [7:0]       connFrameOut,
  output logic [23:0]      airTimingChips,
  output logic             timingValid
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic        awHeld_reg;
  logic [7:0]  awAddr_reg;
  logic        wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [7:0]  frameShift_reg;
  logic [15:0] chipShift_reg;
  logic [7:0]  connIn_reg;
  logic [11:0] cellIn_reg;
  logic        err_reg;
  logic        load_reg;
  logic [7:0]  cellOut_reg;
  logic [7:0]  connOut_reg;
  logic [23:0] air_reg;
  logic        valid_reg;
  logic        doWrite;
  logic [31:0] oldWord;
  logic [31:0] mergedWord;
  logic        writeHit;
  logic        readHit;
  logic        chipBad;
  logic [23:0] scaled;
  logic [23:0] combined;
  logic [7:0]  remainder;
  logic [23:0] lowBound;
  logic [23:0] upBound;
  logic [23:0] air_next;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  function automatic logic [31:0] regValue(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (a)
      ADDR_FRAME_SHIFT: v[7:0]  = frameShift_reg;
      ADDR_CHIP_SHIFT:  v[15:0] = chipShift_reg;
      ADDR_CONN_IN:     v[7:0]  = connIn_reg;
      ADDR_CELL_IN:     v[11:0] = cellIn_reg;
      ADDR_CELL_OUT:    v[7:0]  = cellOut_reg;
      ADDR_CONN_OUT:    v[7:0]  = connOut_reg;
      ADDR_AIR_TIMING:  v[23:0] = air_reg;
      ADDR_STATUS: begin
        v[STAT_ERR_BIT]   = err_reg;
        v[STAT_VALID_BIT] = valid_reg;
      end
      default:          v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_STATUS);
  endfunction

  assign oldWord  = regValue(awAddr_reg);
  assign writeHit = isMapped(awAddr_reg);
  assign readHit  = isMapped(araddr);

  // Byte lanes merged into the addressed word
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign mergedWord[8*i +: 8] = wStrb_reg[i] ? wData_reg[8*i +: 8]
                                                 : oldWord[8*i +: 8];
  end

  // ------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------
  assign awready = !awHeld_reg && !bvalid_reg;
  assign wready  = !wHeld_reg && !bvalid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= wdata;
      wStrb_reg <= wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= writeHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= regValue(araddr);
      rresp_reg  <= readHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Shift and frame inputs
  // ------------------------------------------------------------
  // out of range chip shift refused
  assign chipBad = mergedWord[15:0] > CHIP_SHIFT_MAX;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frameShift_reg <= RST_FRAME;
      connIn_reg     <= RST_FRAME;
      cellIn_reg     <= RST_CELL;
    end else if (doWrite) begin
      if (awAddr_reg == ADDR_FRAME_SHIFT) begin
        frameShift_reg <= mergedWord[7:0];
      end
      if (awAddr_reg == ADDR_CONN_IN) begin
        connIn_reg <= mergedWord[7:0];
      end
      if (awAddr_reg == ADDR_CELL_IN) begin
        cellIn_reg <= mergedWord[11:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chipShift_reg <= RST_CHIP;
    end else if (doWrite && awAddr_reg == ADDR_CHIP_SHIFT && !chipBad) begin
      chipShift_reg <= mergedWord[15:0];
    end
  end

  // Refusal flag, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_reg <= 1'b0;
    end else if (doWrite && awAddr_reg == ADDR_CHIP_SHIFT && chipBad) begin
      err_reg <= 1'b1;
    end else if (doWrite && awAddr_reg == ADDR_STATUS &&
                 mergedWord[STAT_ERR_BIT]) begin
      err_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= doWrite && writeHit && awAddr_reg < ADDR_CELL_OUT
                  && !(awAddr_reg == ADDR_CHIP_SHIFT && chipBad);
    end
  end

  // ------------------------------------------------------------
  // Chip rounding
  // ------------------------------------------------------------
  // frame shift times 38400 plus chip shift
  assign scaled    = 24'(frameShift_reg) * CHIPS_PER_FRAME;
  assign combined  = scaled + 24'(chipShift_reg);
  assign remainder = combined[7:0];
  assign lowBound  = {combined[23:8], 8'h00};
  assign upBound   = lowBound + GRID_CHIPS;

  // grid fixed, no spreading factor input
  always_comb begin
    air_next = combined;
    if (remainder == 8'h00) begin
      air_next = combined;
    end else if (remainder < HALF_GRID) begin
      air_next = lowBound;
    end else begin
      // round up, wrap at 256 frames
      air_next = (upBound == CHIP_CYCLE) ? RST_TIMING : upBound;
    end
  end

  // ------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------
  // whole frame arithmetic, mappings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cellOut_reg <= RST_FRAME;
      connOut_reg <= RST_FRAME;
    end else if (load_reg) begin
      cellOut_reg <= connIn_reg + frameShift_reg;
      connOut_reg <= cellIn_reg[7:0] - frameShift_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      air_reg   <= RST_TIMING;
      valid_reg <= 1'b0;
    end else if (load_reg) begin
      air_reg   <= air_next;
      valid_reg <= 1'b1;
    end
  end

  assign airTimingChips = air_reg;
  assign cellFrameOut   = cellOut_reg;
  assign connFrameOut   = connOut_reg;
  assign timingValid    = valid_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_cell_map_down: assert property (
    @(posedge clk) disable iff (!rst_b)
    load_reg |=> cellFrameOut ==
      8'($past(connIn_reg) + $past(frameShift_reg)))
    else $error("cell frame mapping wrong");

  chk_conn_map_up: assert property (
    @(posedge clk) disable iff (!rst_b)
    load_reg |=> connFrameOut ==
      8'($past(cellIn_reg[7:0]) - $past(frameShift_reg)))
    else $error("connection frame mapping wrong");

  chk_chip_range_held: assert property (
    @(posedge clk) disable iff (!rst_b)
    (doWrite && awAddr_reg == ADDR_CHIP_SHIFT && chipBad)
      |=> $stable(chipShift_reg) && err_reg)
    else $error("bad chip shift accepted");

  chk_grid_aligned: assert property (
    @(posedge clk) disable iff (!rst_b)
    load_reg |=> airTimingChips[7:0] == 8'h00 &&
      airTimingChips < CHIP_CYCLE)
    else $error("timing off 256-chip grid");

  chk_round_down: assert property (
    @(posedge clk) disable iff (!rst_b)
    load_reg && remainder != 8'h00 && remainder < HALF_GRID
      |=> airTimingChips == $past(combined) - 24'($past(remainder)))
    else $error("low remainder not rounded down");

  chk_round_up: assert property (
    @(posedge clk) disable iff (!rst_b)
    load_reg && remainder >= HALF_GRID |=>
      24'(airTimingChips - $past(combined) + CHIP_CYCLE) % CHIP_CYCLE
        <= 24'(HALF_GRID))
    else $error("high remainder not rounded up");

  chk_exact_kept: assert property (
    @(posedge clk) disable iff (!rst_b)
    load_reg && remainder == 8'h00 |=>
      airTimingChips == $past(frameShift_reg) * CHIPS_PER_FRAME
        + 24'($past(chipShift_reg)))
    else $error("aligned count altered");

  chk_result_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    !load_reg |=> $stable(airTimingChips) && $stable(cellFrameOut)
      && $stable(connFrameOut))
    else $error("results moved without new inputs");

  chk_load_latency: assert property (
    @(posedge clk) disable iff (!rst_b)
    doWrite && awAddr_reg == ADDR_FRAME_SHIFT ##1 load_reg
      |=> timingValid)
    else $error("results not one clock after inputs");

endmodule

// *** shared/frame_chip_pkg.sv ***
// Constants for the frame and chip shift mapper
package frame_chip_pkg;

  // --------------------------------------------------------------
  // Frame and chip arithmetic
  // --------------------------------------------------------------
  localparam logic [23:0] CHIPS_PER_FRAME = 24'h009600;
  localparam logic [15:0] CHIP_SHIFT_MAX  = 16'h95FF;
  localparam logic [23:0] CHIP_CYCLE      = 24'h960000;
  localparam logic [23:0] GRID_CHIPS      = 24'h000100;
  localparam logic [7:0]  HALF_GRID       = 8'h80;

  // --------------------------------------------------------------
  // Register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_FRAME_SHIFT = 8'h00;
  localparam logic [7:0] ADDR_CHIP_SHIFT  = 8'h04;
  localparam logic [7:0] ADDR_CONN_IN     = 8'h08;
  localparam logic [7:0] ADDR_CELL_IN     = 8'h0C;
  localparam logic [7:0] ADDR_CELL_OUT    = 8'h10;
  localparam logic [7:0] ADDR_CONN_OUT    = 8'h14;
  localparam logic [7:0] ADDR_AIR_TIMING  = 8'h18;
  localparam logic [7:0] ADDR_STATUS      = 8'h1C;

  // --------------------------------------------------------------
  // Status fields and reset values
  // --------------------------------------------------------------
  localparam int unsigned STAT_ERR_BIT   = 0;
  localparam int unsigned STAT_VALID_BIT = 1;
  localparam logic [7:0]  RST_FRAME      = 8'h00;
  localparam logic [15:0] RST_CHIP       = 16'h0000;
  localparam logic [11:0] RST_CELL       = 12'h000;
  localparam logic [23:0] RST_TIMING     = 24'h000000;

  // --------------------------------------------------------------
  // Bus answers
  // --------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** testbench/shift_controller_model.sv ***
// Network controller model driving the mapper's register bus
`timescale 1ns/1ps
module shift_controller_model
  import frame_chip_pkg::*;
(
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int         readyDelay = 0;
  logic [3:0] strobe     = 4'hF;

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic writeWord(input logic [7:0] addr, input logic [31:0] data,
                           output logic [1:0] resp);
    logic awFire, wFire, bFire;
    int   cnt;
    bit   done;
    cnt = readyDelay;
    done = 0;
    @(posedge clk);
    awaddr <= addr;
    awvalid <= 1'b1;
    wdata <= data;
    wstrb <= strobe;
    wvalid <= 1'b1;
    bready <= (cnt == 0);
    while (!done) begin
      @(negedge clk);
      awFire = awvalid && awready;
      wFire = wvalid && wready;
      bFire = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (awFire) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wFire) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bFire) begin
        bready <= 1'b0;
        done = 1;
      end else begin
        if (cnt > 0) cnt--;
        if (cnt == 0) bready <= 1'b1;
      end
    end
  endtask

  task automatic readWord(input logic [7:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic arFire, rFire;
    int   cnt;
    bit   done;
    cnt = readyDelay;
    done = 0;
    @(posedge clk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= (cnt == 0);
    while (!done) begin
      @(negedge clk);
      arFire = arvalid && arready;
      rFire = rvalid && rready;
      data = rdata;
      resp = rresp;
      @(posedge clk);
      if (arFire) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (rFire) begin
        rready <= 1'b0;
        done = 1;
      end else begin
        if (cnt > 0) cnt--;
        if (cnt == 0) rready <= 1'b1;
      end
    end
  endtask

  task automatic setLink(input logic [7:0] fs, input logic [15:0] cs);
    logic [1:0] resp;
    writeWord(ADDR_FRAME_SHIFT, {24'h000000, fs}, resp);
    writeWord(ADDR_CHIP_SHIFT, {16'h0000, cs}, resp);
  endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the frame and chip shift mapper
`timescale 1ns/1ps
module tb_top;
  import frame_chip_pkg::*;
  logic        clk, rstB, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, timingValid;
  logic [7:0]  awaddr, araddr, cellFrameOut, connFrameOut;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [23:0] airTimingChips;
  int          numErrors = 0;
  int          totalChecks = 0;
  logic [7:0]  fsTab [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
  logic [7:0]  cnTab [4] = '{8'h00, 8'hFF, 8'h05, 8'h7F};
  logic [11:0] ceTab [4] = '{12'h000, 12'h000, 12'hA03, 12'hF10};
  logic [7:0]  rfTab [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h02, 8'h10};
  logic [15:0] rcTab [7] = '{16'h0000, 16'h007F, 16'h0080, 16'h00FF,
                             16'h95FF, 16'h0001, 16'h0181};

  frame_chip_offset_mapper uut (
    .clk(clk), .rst_b(rstB), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cellFrameOut(cellFrameOut), .connFrameOut(connFrameOut),
    .airTimingChips(airTimingChips), .timingValid(timingValid)
  );

  shift_controller_model ctrl (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    ctrl.writeWord(a, d, r);
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    ctrl.readWord(a, d, r);
    check("rresp", {30'h0, er}, {30'h0, r});
    check("rdata", e, d);
  endtask

  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic [23:0] expRound(input logic [7:0] fs,
                                           input logic [15:0] cs);
    logic [31:0] c;
    c = fs * 38400 + cs;
    if (c[7:0] >= 8'h80) c = c - c[7:0] + 32'h00000100;
    else c = c - c[7:0];
    if (c >= 32'h00960000) c = c - 32'h00960000;
    return c[23:0];
  endfunction

  task automatic tallyAndFinish;
    $display("Checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rstB = 1'b0;
    repeat (2) @(posedge clk);
    rstB <= 1'b1;
    @(negedge clk);
    check("timingValid", 32'h0, {31'h0, timingValid});
    rd(ADDR_AIR_TIMING, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      ctrl.readyDelay = i % 3;
      ctrl.setLink(fsTab[i], 16'h0000);
      wr(ADDR_CONN_IN, {24'h0, cnTab[i]}, RESP_OKAY);
      wr(ADDR_CELL_IN, {20'h0, ceTab[i]}, RESP_OKAY);
      settle();
      check("cellFrameOut", {24'h0, 8'(cnTab[i] + fsTab[i])},
            {24'h0, cellFrameOut});
      check("connFrameOut", {24'h0, 8'(ceTab[i][7:0] - fsTab[i])},
            {24'h0, connFrameOut});
      rd(ADDR_CELL_OUT, {24'h0, 8'(cnTab[i] + fsTab[i])}, RESP_OKAY);
      rd(ADDR_CONN_OUT, {24'h0, 8'(ceTab[i][7:0] - fsTab[i])},
         RESP_OKAY);
    end
    for (int i = 0; i < 7; i++) begin
      ctrl.readyDelay = i % 2;
      ctrl.setLink(rfTab[i], rcTab[i]);
      settle();
      check("airTiming", {8'h0, expRound(rfTab[i], rcTab[i])},
            {8'h0, airTimingChips});
      rd(ADDR_AIR_TIMING, {8'h0, expRound(rfTab[i], rcTab[i])},
         RESP_OKAY);
      check("timingValid", 32'h1, {31'h0, timingValid});
    end
    wr(ADDR_CHIP_SHIFT, 32'h00009600, RESP_OKAY);
    rd(ADDR_CHIP_SHIFT, 32'h00000181, RESP_OKAY);
    rd(ADDR_STATUS, 32'h00000003, RESP_OKAY);
    wr(ADDR_STATUS, 32'h00000001, RESP_OKAY);
    rd(ADDR_STATUS, 32'h00000002, RESP_OKAY);
    ctrl.strobe = 4'h1;
    wr(ADDR_CHIP_SHIFT, 32'hFFFF00AA, RESP_OKAY);
    ctrl.strobe = 4'hF;
    rd(ADDR_CHIP_SHIFT, 32'h000001AA, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h02, 32'h00000055, RESP_SLVERR);
    wr(ADDR_AIR_TIMING, 32'hFFFFFFFF, RESP_OKAY);
    settle();
    check("airHeld", {8'h0, expRound(8'h10, 16'h01AA)},
          {8'h0, airTimingChips});
    tallyAndFinish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    tallyAndFinish();
  end
endmodule
